// [verilog/cwd_map.svh]
// Summary of operation
// [RULE_01] Selector 10 blocks top 256-word region
// [RULE_02] Selector 01 protects upper half of memory
// [RULE_03] Selector 00 protects all program memory
// [RULE_04] Debug bit low dedicates both debug pins
// [RULE_05] Unused config bit always reads one
// [RULE_06] Self-write permit gates unprotected memory writes
// [RULE_07] Data EEPROM protect bit low blocks access
// [RULE_08] Low-voltage bit selects programming pin function
// [RULE_09] Brown-out enable bit turns brown-out reset on
// [RULE_10] Power-up delay bit low runs timer
// [RULE_11] Oscillator 11 RC, 10 high-speed crystal
// [RULE_12] Oscillator 01 standard, 00 low-power crystal
// [RULE_13] Selector 11 means no code protection
// [RULE_14] Watchdog enable bit turns watchdog on
`ifndef CWD_MAP_SVH
`define CWD_MAP_SVH

// ==========================================================
// Register offsets
`define CWD_OFS_CFG       4'h0
`define CWD_OFS_STAT      4'h1

// ==========================================================
// Reset values
`define CWD_CFG_RST       14'h3FFF
`define CWD_RDATA_RST     16'h0000

// ==========================================================
// Field positions in the configuration word
`define CWD_POS_FOSC_LO   0
`define CWD_POS_FOSC_HI   1
`define CWD_POS_WATCHDOG_EN      2
`define CWD_POS_POWERUP_DELAY_EN_N     3
`define CWD_POS_CP_LO     4
`define CWD_POS_CP_HI     5
`define CWD_POS_BROWNOUT_RESET_EN     6
`define CWD_POS_LVP       7
`define CWD_POS_CPD       8
`define CWD_POS_WRT       9
`define CWD_POS_UNIMP     10
`define CWD_POS_DEBUG     11

// ==========================================================
// Protection bounds
`define CWD_LG_TOP_LO     13'h1F00
`define CWD_LG_HALF_LO    13'h1000
`define CWD_LG_END        13'h1FFF
`define CWD_SM_TOP_LO     13'h0F00
`define CWD_SM_HALF_LO    13'h0800
`define CWD_SM_END        13'h0FFF
`define CWD_MEM_START     13'h0000

`endif

// [verilog/cwd_pkg.sv]
`default_nettype none
package cwd_pkg;
    typedef enum logic [1:0] {
        CWD_PROT_ALL  = 2'h0,
        CWD_PROT_HALF = 2'h1,
        CWD_PROT_TOP  = 2'h2,
        CWD_PROT_NONE = 2'h3
    } cwd_prot_e;

    typedef enum logic [1:0] {
        CWD_OSC_LP = 2'h0,
        CWD_OSC_XT = 2'h1,
        CWD_OSC_HS = 2'h2,
        CWD_OSC_RC = 2'h3
    } cwd_osc_e;

    typedef logic [12:0] cwd_addr_t;
    typedef logic [13:0] cwd_word_t;
endpackage : cwd_pkg
`default_nettype wire

// [verilog/cwd_range_chk.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cwd_map.svh"
module cwd_range_chk
    import cwd_pkg::*;
(
    input  wire cwd_prot_e sel,
    input  wire logic      large_mem,
    input  wire cwd_addr_t addr,
    output logic           prot_hit
);
    // ======================================================
    // Region compare
    always_comb begin
        prot_hit = 1'b0;
        case (sel)
            CWD_PROT_NONE: prot_hit = 1'b0; // [RULE_13]
            CWD_PROT_TOP: begin
                if (large_mem) begin
                    prot_hit = (addr >= `CWD_LG_TOP_LO) &&
                               (addr <= `CWD_LG_END); // [RULE_01]
                end else begin
                    prot_hit = (addr >= `CWD_SM_TOP_LO) &&
                               (addr <= `CWD_SM_END); // [RULE_01]
                end
            end
            CWD_PROT_HALF: begin
                if (large_mem) begin
                    prot_hit = (addr >= `CWD_LG_HALF_LO) &&
                               (addr <= `CWD_LG_END); // [RULE_02]
                end else begin
                    prot_hit = (addr >= `CWD_SM_HALF_LO) &&
                               (addr <= `CWD_SM_END); // [RULE_02]
                end
            end
            CWD_PROT_ALL: begin
                if (large_mem) begin
                    prot_hit = (addr >= `CWD_MEM_START) &&
                               (addr <= `CWD_LG_END); // [RULE_03]
                end else begin
                    prot_hit = (addr >= `CWD_MEM_START) &&
                               (addr <= `CWD_SM_END); // [RULE_03]
                end
            end
            default: prot_hit = 1'b0;
        endcase
    end
endmodule : cwd_range_chk
`default_nettype wire

// [verilog/cwd_top.sv]
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "cwd_map.svh"
module cwd_top
    import cwd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        large_mem_strap,
    input  wire cwd_addr_t   ext_addr,
    output logic             ext_addr_block,
    input  wire cwd_addr_t   selfprog_addr,
    input  wire logic        selfprog_wr_req,
    output logic             selfprog_wr_allow,
    output logic             selfprog_wr_refuse,
    output logic             eeprom_ext_block,
    output logic             debug_en,
    output logic             debug_pin_a_gpio,
    output logic             debug_pin_b_gpio,
    output logic             prog_mode_pin_pgm,
    output logic             master_clear_hv_prog,
    output logic             brownout_reset_en,
    output logic             powerup_delay_run,
    output logic             watchdog_en,
    output cwd_osc_e         osc_mode_sel
);
    cwd_word_t   cfg_r;
    logic        large_r;
    logic        strap_done_r;
    logic        ext_hit;
    logic        sp_hit;
    cwd_prot_e   prot_sel;
    logic [15:0] rdata_nxt;

    assign prot_sel = cwd_prot_e'(cfg_r[`CWD_POS_CP_HI:`CWD_POS_CP_LO]);

    // ======================================================
    // Configuration word storage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_r <= `CWD_CFG_RST;
        end else if (reg_wr && reg_addr == `CWD_OFS_CFG) begin
            cfg_r <= reg_wdata[13:0];
            cfg_r[`CWD_POS_UNIMP] <= 1'b1; // [RULE_05]
        end
    end

    // ======================================================
    // Memory size strap, caught after reset release
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            large_r      <= 1'b0;
            strap_done_r <= 1'b0;
        end else if (!strap_done_r) begin
            large_r      <= large_mem_strap;
            strap_done_r <= 1'b1;
        end
    end

    // ======================================================
    // Protection range checks
    cwd_range_chk u_ext_chk (
        .sel       (prot_sel),
        .large_mem (large_r),
        .addr      (ext_addr),
        .prot_hit  (ext_hit)
    );

    cwd_range_chk u_sp_chk (
        .sel       (prot_sel),
        .large_mem (large_r),
        .addr      (selfprog_addr),
        .prot_hit  (sp_hit)
    );

    // ======================================================
    // External access blocking
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ext_addr_block   <= 1'b0;
            eeprom_ext_block <= 1'b0;
        end else begin
            ext_addr_block   <= ext_hit; // [RULE_01]
            eeprom_ext_block <= ~cfg_r[`CWD_POS_CPD]; // [RULE_07]
        end
    end

    // ======================================================
    // Self-programming write permission
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            selfprog_wr_allow  <= 1'b0;
            selfprog_wr_refuse <= 1'b0;
        end else begin
            selfprog_wr_allow  <= selfprog_wr_req &&
                                  cfg_r[`CWD_POS_WRT] && !sp_hit; // [RULE_06]
            selfprog_wr_refuse <= selfprog_wr_req &&
                                  !(cfg_r[`CWD_POS_WRT] && !sp_hit); // [RULE_06]
        end
    end

    // ======================================================
    // Pin function selection
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            debug_en             <= 1'b0;
            debug_pin_a_gpio     <= 1'b1;
            debug_pin_b_gpio     <= 1'b1;
            prog_mode_pin_pgm    <= 1'b1;
            master_clear_hv_prog <= 1'b0;
        end else begin
            debug_en             <= ~cfg_r[`CWD_POS_DEBUG]; // [RULE_04]
            debug_pin_a_gpio     <= cfg_r[`CWD_POS_DEBUG]; // [RULE_04]
            debug_pin_b_gpio     <= cfg_r[`CWD_POS_DEBUG]; // [RULE_04]
            prog_mode_pin_pgm    <= cfg_r[`CWD_POS_LVP]; // [RULE_08]
            master_clear_hv_prog <= ~cfg_r[`CWD_POS_LVP]; // [RULE_08]
        end
    end

    // ======================================================
    // Reset, timer and watchdog enables
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            brownout_reset_en <= 1'b1;
            powerup_delay_run <= 1'b0;
            watchdog_en       <= 1'b1;
        end else begin
            brownout_reset_en <= cfg_r[`CWD_POS_BROWNOUT_RESET_EN]; // [RULE_09]
            powerup_delay_run <= ~cfg_r[`CWD_POS_POWERUP_DELAY_EN_N]; // [RULE_10]
            watchdog_en       <= cfg_r[`CWD_POS_WATCHDOG_EN]; // [RULE_14]
        end
    end

    // ======================================================
    // Oscillator mode
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            osc_mode_sel <= CWD_OSC_RC;
        end else begin
            case (cfg_r[`CWD_POS_FOSC_HI:`CWD_POS_FOSC_LO])
                2'h3:    osc_mode_sel <= CWD_OSC_RC; // [RULE_11]
                2'h2:    osc_mode_sel <= CWD_OSC_HS; // [RULE_11]
                2'h1:    osc_mode_sel <= CWD_OSC_XT; // [RULE_12]
                2'h0:    osc_mode_sel <= CWD_OSC_LP; // [RULE_12]
                default: osc_mode_sel <= CWD_OSC_RC;
            endcase
        end
    end

    // ======================================================
    // Register read path
    always_comb begin
        rdata_nxt = `CWD_RDATA_RST;
        case (reg_addr)
            `CWD_OFS_CFG: begin
                rdata_nxt = {2'h0, cfg_r};
                rdata_nxt[`CWD_POS_UNIMP] = 1'b1; // [RULE_05]
            end
            `CWD_OFS_STAT: begin
                rdata_nxt = {8'h00, large_r, ext_addr_block,
                             eeprom_ext_block, debug_en,
                             prog_mode_pin_pgm, brownout_reset_en,
                             powerup_delay_run, watchdog_en};
            end
            default: rdata_nxt = `CWD_RDATA_RST;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= `CWD_RDATA_RST;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end else begin
            reg_rdata <= `CWD_RDATA_RST;
        end
    end
endmodule : cwd_top
`default_nettype wire

// [verilog/cwd_pkg_order_note_unused.sv]
`default_nettype none
`default_nettype wire

// [dv/cwd_prog_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cwd_prog_model (
    input  wire logic        clk,
    input  wire logic [21:0] cmd,
    output var  logic        reg_wr,
    output var  logic        reg_rd,
    output var  logic [3:0]  reg_addr,
    output var  logic [15:0] reg_wdata
);
    // ==========================================================
    // Programmer: one-cycle strobes, idle lines keep changing
    logic [3:0] idle_cnt = 4'h0;
    always @(posedge clk) begin
        idle_cnt  <= idle_cnt + 4'h1;
        reg_wr    <= cmd[21] & cmd[20];
        reg_rd    <= cmd[21] & ~cmd[20];
        reg_addr  <= cmd[21] ? cmd[19:16] : idle_cnt;
        reg_wdata <= cmd[21] ? cmd[15:0] : {4{idle_cnt}};
    end
endmodule : cwd_prog_model
`default_nettype wire

// [dv/cwd_top_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module cwd_top_checker
    import cwd_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        selfprog_wr_req,
    input wire logic        selfprog_wr_allow,
    input wire logic        selfprog_wr_refuse,
    input wire logic        eeprom_ext_block,
    input wire logic        debug_en,
    input wire logic        debug_pin_a_gpio,
    input wire logic        debug_pin_b_gpio,
    input wire logic        prog_mode_pin_pgm,
    input wire logic        brownout_reset_en,
    input wire logic        powerup_delay_run,
    input wire logic        watchdog_en,
    input wire cwd_osc_e    osc_mode_sel
);
    // ==========================================================
    // Decoded outputs against the written word
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence wr0;
        reg_wr && reg_addr == 4'h0 ##1 !(reg_wr && reg_addr == 4'h0);
    endsequence
    a_pins_pair: assert property (
        debug_pin_a_gpio != debug_en && debug_pin_b_gpio != debug_en)
        else $error("debug pins");
    a_dbg_follow: assert property (
        wr0 |=> debug_en == !$past(reg_wdata[11], 2)) else $error("dbg");
    a_pgm_follow: assert property (
        wr0 |=> prog_mode_pin_pgm == $past(reg_wdata[7], 2))
        else $error("pgm");
    a_ee_follow: assert property (
        wr0 |=> eeprom_ext_block == !$past(reg_wdata[8], 2)) else $error("ee");
    a_bor_follow: assert property (
        wr0 |=> brownout_reset_en == $past(reg_wdata[6], 2))
        else $error("bor");
    a_powerup_timer_follow: assert property (
        wr0 |=> powerup_delay_run == !$past(reg_wdata[3], 2))
        else $error("pwr");
    a_wdt_follow: assert property (
        wr0 |=> watchdog_en == $past(reg_wdata[2], 2)) else $error("wdt");
    a_osc_follow: assert property (
        wr0 |=> osc_mode_sel == $past(reg_wdata[1:0], 2)) else $error("osc");
    a_unimp_one: assert property (
        reg_rd && reg_addr == 4'h0 |=> reg_rdata[10] && !reg_rdata[15:14])
        else $error("bit 10");
    a_selfwr_one: assert property (
        selfprog_wr_req |=> selfprog_wr_allow != selfprog_wr_refuse)
        else $error("self write");
    c_cfg_wr: cover property (wr0);
    c_refuse: cover property (selfprog_wr_req ##1 selfprog_wr_refuse);
    c_allow: cover property (selfprog_wr_req ##1 selfprog_wr_allow);
endmodule : cwd_top_checker
bind cwd_top cwd_top_checker i_chk (
    .clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .selfprog_wr_req, .selfprog_wr_allow, .selfprog_wr_refuse,
    .eeprom_ext_block, .debug_en, .debug_pin_a_gpio, .debug_pin_b_gpio,
    .prog_mode_pin_pgm, .brownout_reset_en, .powerup_delay_run,
    .watchdog_en, .osc_mode_sel
);
`default_nettype wire

// [dv/test_cwd_top.sv]
`timescale 1ns/1ps
`default_nettype none
module test_cwd_top;
    logic        clk = 1'b0, sys_rst = 1'b1, large_mem_strap = 1'b1;
    logic        selfprog_wr_req = 1'b0;
    logic [21:0] cmd = 22'h000000;
    logic [12:0] ext_addr = 13'h0000, selfprog_addr = 13'h0000;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic        reg_wr, reg_rd, ext_addr_block, selfprog_wr_allow;
    logic        selfprog_wr_refuse, eeprom_ext_block, debug_en;
    logic        debug_pin_a_gpio, debug_pin_b_gpio, prog_mode_pin_pgm;
    logic        master_clear_hv_prog, brownout_reset_en, powerup_delay_run;
    logic        watchdog_en;
    logic [1:0]  osc_mode_sel;
    int          mismatches = 0, samples_checked = 0;
    logic [13:0] tbl [4] = '{14'h0000, 14'h3FFF, 14'h0A55, 14'h35AA};
    logic [12:0] pa [10] = '{13'h0000, 13'h07FF, 13'h0800, 13'h0EFF,
        13'h0F00, 13'h0FFF, 13'h1000, 13'h1EFF, 13'h1F00, 13'h1FFF};

    always #2.5 clk = ~clk;
    cwd_prog_model i_prog (.clk, .cmd, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata);
    cwd_top i_dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .large_mem_strap, .ext_addr, .ext_addr_block,
        .selfprog_addr, .selfprog_wr_req, .selfprog_wr_allow,
        .selfprog_wr_refuse, .eeprom_ext_block, .debug_en, .debug_pin_a_gpio,
        .debug_pin_b_gpio, .prog_mode_pin_pgm, .master_clear_hv_prog,
        .brownout_reset_en, .powerup_delay_run, .watchdog_en, .osc_mode_sel);

    // ==========================================================
    // Bus and compare tasks
    task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic bus(logic wr, logic [3:0] a, logic [15:0] d);
        @(posedge clk);
        cmd <= {1'b1, wr, a, d};
        @(posedge clk);
        cmd[21] <= 1'b0;
    endtask : bus
    task automatic rd(logic [3:0] a, logic [15:0] exp);
        bus(1'b0, a, 16'h0000);
        @(posedge clk);
        #1 chk("rdata", reg_rdata, exp);
    endtask : rd
    task automatic do_reset(logic lg);
        @(posedge clk);
        large_mem_strap <= lg;
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : do_reset
    task automatic chk_dec(logic [13:0] w);
        chk("debug_en", debug_en, !w[11]);
        chk("pin_a", debug_pin_a_gpio, w[11]);
        chk("pin_b", debug_pin_b_gpio, w[11]);
        chk("ee_block", eeprom_ext_block, !w[8]);
        chk("pgm", prog_mode_pin_pgm, w[7]);
        chk("hv", master_clear_hv_prog, !w[7]);
        chk("bor", brownout_reset_en, w[6]);
        chk("powerup_timer", powerup_delay_run, !w[3]);
        chk("wdt", watchdog_en, w[2]);
        chk("osc", osc_mode_sel, w[1:0]);
    endtask : chk_dec
    function automatic logic prot(logic [1:0] s, logic lg, logic [12:0] a);
        logic [12:0] top;
        top = lg ? 13'h1FFF : 13'h0FFF;
        case (s)
            2'h2:    return a >= top - 13'h00FF && a <= top;
            2'h1:    return a >= (lg ? 13'h1000 : 13'h0800) && a <= top;
            2'h0:    return a <= top;
            default: return 1'b0;
        endcase
    endfunction : prot
    task automatic probe(logic [1:0] s, logic lg, logic wp);
        logic p;
        bus(1'b1, 4'h0, {2'h0, 4'hF, wp, 3'h7, s, 4'hF});
        repeat (2) @(posedge clk);
        foreach (pa[i]) begin
            @(posedge clk);
            ext_addr <= pa[i];
            selfprog_addr <= pa[i];
            selfprog_wr_req <= 1'b1;
            @(posedge clk);
            selfprog_wr_req <= 1'b0;
            #1;
            p = prot(s, lg, pa[i]);
            chk("ext_block", ext_addr_block, p);
            chk("allow", selfprog_wr_allow, wp & !p);
            chk("refuse", selfprog_wr_refuse, !wp | p);
        end
    endtask : probe
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    // ==========================================================
    // Main sequence
    initial begin
        for (int lg = 1; lg >= 0; lg--) begin
            do_reset(lg[0]);
            rd(4'h0, 16'h3FFF);
            rd(4'h1, {8'h00, lg[0], 7'h0D});
            chk_dec(14'h3FFF);
            probe(2'h2, lg[0], 1'b1);
            probe(2'h1, lg[0], 1'b1);
            probe(2'h0, lg[0], 1'b1);
            probe(2'h3, lg[0], 1'b1);
            probe(2'h3, lg[0], 1'b0);
        end
        $display("test protection done");
        foreach (tbl[i]) begin
            bus(1'b1, 4'h0, {2'h0, tbl[i]});
            rd(4'h0, {2'h0, tbl[i] | 14'h0400});
            chk_dec(tbl[i]);
        end
        bus(1'b1, 4'h2, 16'h0000);
        bus(1'b1, 4'h1, 16'h0000);
        rd(4'h2, 16'h0000);
        rd(4'h0, 16'h35AA | 16'h0400);
        rd(4'h1, 16'h0018);
        $display("test decode done");
        final_report;
    end
    initial begin
        #100000;
        mismatches++;
        final_report;
    end
endmodule : test_cwd_top
`default_nettype wire
